/* rtl/cob_map.vh */
// register map, operand fields, reset values and opcodes of the cp block
`ifndef COB_MAP_VH
`define COB_MAP_VH

// ----------------------------------------------------------------
// coprocessor register selectors
// ----------------------------------------------------------------
`define COB_CRN_CACHE 4'h7
`define COB_CRN_TCM 4'h9
`define COB_CRM_REGION 4'h1
`define COB_OP2_REGION 3'h0

// ----------------------------------------------------------------
// cache register operations (crm / opcode2)
// ----------------------------------------------------------------
`define COB_CRM_BARRIER 4'ha
`define COB_OP2_DSB 3'h4
`define COB_OP2_DMB 3'h5
`define COB_CRM_WFI 4'h0
`define COB_OP2_WFI 3'h4
`define COB_CRM_IBR 4'h5
`define COB_OP2_PFB 3'h4
`define COB_OP2_BP_ALL 3'h6
`define COB_OP2_BP_LINE 3'h7
`define COB_CRM_INV 4'h6
`define COB_CRM_CLN 4'ha
`define COB_CRM_CLN_INV 4'he
`define COB_OP2_BY_ADDR 3'h1
`define COB_OP2_BY_SETWAY 3'h2

// ----------------------------------------------------------------
// maintenance operand fields
// ----------------------------------------------------------------
`define COB_WAY_MSB 31
`define COB_WAY_LSB 30
`define COB_SET_LSB 5
`define COB_ADDR_MSB 31
`define COB_ADDR_LSB 5
`define COB_CACHE_LOG2_KB 2

// ----------------------------------------------------------------
// region register fields
// ----------------------------------------------------------------
`define COB_BASE_MSB 31
`define COB_BASE_LSB 12
`define COB_SIZE_MSB 6
`define COB_SIZE_LSB 2
`define COB_EN_BIT 0
`define COB_RSVD_READ 5'h00
`define COB_SIZE_0KB 5'h00
`define COB_SIZE_4KB 5'h03
`define COB_SIZE_8MB 5'h0e
`define COB_SIZE_RESET 5'h07
`define COB_BASE_ZERO 20'h0_0000
`define COB_BASE_IMPL 20'h0_0400
`define COB_LOG2_4KB 5'h0c
`define COB_MIN_RESET_EDGES 3

`endif

/* rtl/cob_sync2.v */
// two flip-flop synchroniser for slow strap pins
`timescale 1ns/1ns
`default_nettype none

module cob_sync2 #(
    parameter W = 2
) (
    // clock
    input wire clk_i,
    // asynchronous level in, synchronised level out
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    // ----------------------------------------------------------------
    // chain
    // ----------------------------------------------------------------
    // no reset: the chain must run during reset so straps are caught
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk_i) begin
        meta_r <= async_i;
        sync_r <= meta_r;
    end

    assign sync_o = sync_r;

endmodule

`default_nettype wire

/* rtl/cob_maint_dec.v */
// decoder of cache maintenance selectors and operand fields
`timescale 1ns/1ns
`default_nettype none
`include "cob_map.vh"

module cob_maint_dec #(
    parameter SET_W = 5
) (
    // selectors of the write
    input wire [3:0] crm_i,
    input wire [2:0] op2_i,
    input wire [31:0] operand_i,
    // decoded operation
    output reg op_valid_o,
    output reg op_setway_o,
    output reg op_clean_o,
    output reg op_inval_o,
    // operand fields
    output wire [1:0] way_o,
    output wire [SET_W-1:0] set_o,
    output wire [26:0] addr_o
);

    // ----------------------------------------------------------------
    // operation kind
    // ----------------------------------------------------------------
    always @* begin
        op_setway_o = (op2_i == `COB_OP2_BY_SETWAY);
        op_valid_o = (op2_i == `COB_OP2_BY_SETWAY) ||
                     (op2_i == `COB_OP2_BY_ADDR);
        op_clean_o = 1'b0;
        op_inval_o = 1'b0;
        case (crm_i)
            `COB_CRM_INV: begin
                op_inval_o = 1'b1;
            end
            `COB_CRM_CLN: begin
                op_clean_o = 1'b1;
            end
            `COB_CRM_CLN_INV: begin
                op_clean_o = 1'b1;
                op_inval_o = 1'b1;
            end
            default: begin
                op_valid_o = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // fields; bits between set and way and below bit 5 are dropped
    // ----------------------------------------------------------------
    assign way_o = operand_i[`COB_WAY_MSB:`COB_WAY_LSB];
    assign set_o = operand_i[SET_W+`COB_SET_LSB-1:`COB_SET_LSB];
    assign addr_o = operand_i[`COB_ADDR_MSB:`COB_ADDR_LSB];

endmodule

`default_nettype wire

/* rtl/cob_cp_ctrl.v */
// coprocessor control: cache maintenance, barriers, second ram region
// What this block does
// - way selector is operand bits 31 to 30
// - set index starts at bit five
// - set width follows cache size, 5 to 9
// - address operations use operand bits 31 to 5
// - sync barrier holds all later instructions
// - sync barrier: write, crm 10, op2 4, any mode
// - memory barrier holds later memory transactions and later barriers only
// - memory barrier: write, crm 10, op2 5, any mode
// - region base bits 31:12, low bits ignored
// - reset base chosen by zero-location strap
// - bits 11 to 7 unpredictable, bit 1 zero
// - size field read-only, writes ignored
// - size code 0 none, 3 is 4KB, doubling
// - bit 0 enables ram, reset from strap
// - region register privileged only, crm 1 op2 0
// - unlisted or read cache register is undefined
`timescale 1ns/1ns
`default_nettype none
`include "cob_map.vh"

module cob_cp_ctrl #(
    parameter CACHE_LOG2_KB = `COB_CACHE_LOG2_KB,
    parameter [4:0] RAM_SIZE_CODE = `COB_SIZE_RESET,
    parameter [19:0] IMPL_BASE = `COB_BASE_IMPL
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // straps from pins
    input wire local_ram_at_zero_strap_i,
    input wire local_ram_enable_strap_i,
    // coprocessor instruction port
    input wire cp_valid_i,
    input wire cp_write_i,
    input wire cp_priv_i,
    input wire [3:0] cp_crn_i,
    input wire [3:0] cp_crm_i,
    input wire [2:0] cp_op2_i,
    input wire [31:0] cp_wdata_i,
    output wire cp_ready_o,
    output wire cp_done_o,
    output wire cp_undef_o,
    output wire [31:0] cp_rdata_o,
    // memory system
    input wire mem_outstanding_i,
    output wire hold_instr_o,
    output wire hold_mem_o,
    // cache maintenance request
    output wire maint_valid_o,
    output wire maint_setway_o,
    output wire maint_clean_o,
    output wire maint_inval_o,
    output wire [1:0] maint_way_o,
    output wire [CACHE_LOG2_KB+2:0] maint_set_o,
    output wire [26:0] maint_addr_o,
    // second local ram region
    output wire [19:0] ram_base_o,
    output wire [4:0] ram_size_code_o,
    output wire ram_enable_o
);

    // ----------------------------------------------------------------
    // sizes and states
    // ----------------------------------------------------------------
    // 4KB cache gives five set bits, one more per doubling
    localparam SET_W = CACHE_LOG2_KB + 3;
    localparam ST_IDLE = 2'd0;
    localparam ST_DSB = 2'd1;
    localparam ST_DMB = 2'd2;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // base bits below log2 of the ram size are don't care
    function [19:0] cob_base_mask;
        input [4:0] code;
        reg [4:0] low;
        integer i;
        begin
            low = 5'h00;
            if (code >= `COB_SIZE_4KB && code <= `COB_SIZE_8MB) begin
                low = code - `COB_SIZE_4KB;
            end
            for (i = 0; i < 20; i = i + 1) begin
                cob_base_mask[i] = (i >= low);
            end
        end
    endfunction

    // log2 of the ram size in bytes, zero when there is no ram
    function [4:0] cob_size_log2;
        input [4:0] code;
        begin
            if (code == `COB_SIZE_0KB) begin
                cob_size_log2 = 5'h00;
            end else begin
                cob_size_log2 = code - `COB_SIZE_4KB + `COB_LOG2_4KB;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // strap synchronisers
    // ----------------------------------------------------------------
    wire [1:0] strap_s;

    cob_sync2 #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .async_i({local_ram_enable_strap_i, local_ram_at_zero_strap_i}),
        .sync_o(strap_s)
    );

    // ----------------------------------------------------------------
    // maintenance decode
    // ----------------------------------------------------------------
    wire dec_valid;
    wire dec_setway;
    wire dec_clean;
    wire dec_inval;
    wire [1:0] dec_way;
    wire [SET_W-1:0] dec_set;
    wire [26:0] dec_addr;

    // upper operand bits are not checked; software keeps them zero
    cob_maint_dec #(
        .SET_W(SET_W)
    ) u_dec (
        .crm_i(cp_crm_i),
        .op2_i(cp_op2_i),
        .operand_i(cp_wdata_i),
        .op_valid_o(dec_valid),
        .op_setway_o(dec_setway),
        .op_clean_o(dec_clean),
        .op_inval_o(dec_inval),
        .way_o(dec_way),
        .set_o(dec_set),
        .addr_o(dec_addr)
    );

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    wire is_c7;
    wire is_dsb;
    wire is_dmb;
    wire is_pfb;
    wire is_nop;
    wire c7_listed;
    wire c7_user_ok;
    wire is_region;
    wire claimed;
    wire bad;
    wire take;

    assign is_c7 = (cp_crn_i == `COB_CRN_CACHE);
    assign is_dsb = is_c7 && (cp_crm_i == `COB_CRM_BARRIER) &&
                    (cp_op2_i == `COB_OP2_DSB);
    assign is_dmb = is_c7 && (cp_crm_i == `COB_CRM_BARRIER) &&
                    (cp_op2_i == `COB_OP2_DMB);
    assign is_pfb = is_c7 && (cp_crm_i == `COB_CRM_IBR) &&
                    (cp_op2_i == `COB_OP2_PFB);
    // these operations are plain no-ops here
    assign is_nop = is_c7 &&
                    (((cp_crm_i == `COB_CRM_WFI) &&
                      (cp_op2_i == `COB_OP2_WFI)) ||
                     ((cp_crm_i == `COB_CRM_IBR) &&
                      ((cp_op2_i == `COB_OP2_BP_ALL) ||
                       (cp_op2_i == `COB_OP2_BP_LINE))));
    assign c7_listed = is_dsb || is_dmb || is_pfb || is_nop ||
                       (is_c7 && dec_valid);
    assign c7_user_ok = is_dsb || is_dmb || is_pfb;
    assign is_region = (cp_crn_i == `COB_CRN_TCM) &&
                       (cp_crm_i == `COB_CRM_REGION) &&
                       (cp_op2_i == `COB_OP2_REGION);
    // other coprocessor registers belong to other blocks
    assign claimed = is_c7 || is_region;
    assign bad = (is_c7 && (!cp_write_i || !c7_listed ||
                            (!cp_priv_i && !c7_user_ok))) ||
                 (is_region && !cp_priv_i);

    // a sync barrier stalls the port; a memory barrier stalls only
    // another barrier, so plain instructions keep flowing
    assign cp_ready_o = (state_r != ST_DSB) &&
                        !((state_r == ST_DMB) &&
                          (is_dsb || is_dmb));
    assign take = cp_valid_i && cp_ready_o;

    // ----------------------------------------------------------------
    // barrier state machine
    // ----------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take && !bad && is_dsb) begin
                    state_nxt = ST_DSB;
                end else if (take && !bad && is_dmb) begin
                    state_nxt = ST_DMB;
                end
            end
            ST_DSB: begin
                if (!mem_outstanding_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DMB: begin
                if (!mem_outstanding_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // answers and maintenance requests
    // ----------------------------------------------------------------
    reg done_r;
    reg undef_r;
    reg [31:0] rdata_r;
    reg maint_valid_r;
    reg maint_setway_r;
    reg maint_clean_r;
    reg maint_inval_r;
    reg [1:0] maint_way_r;
    reg [SET_W-1:0] maint_set_r;
    reg [26:0] maint_addr_r;
    reg [19:0] base_r;
    reg en_r;
    wire region_word_en;
    wire [31:0] region_word;

    // reserved bits read as zero, size is the fixed build value
    assign region_word = {base_r, `COB_RSVD_READ, RAM_SIZE_CODE,
                          1'b0, en_r};
    assign region_word_en = take && is_region && !bad;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            done_r <= 1'b0;
            undef_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            maint_valid_r <= 1'b0;
            maint_setway_r <= 1'b0;
            maint_clean_r <= 1'b0;
            maint_inval_r <= 1'b0;
            maint_way_r <= 2'h0;
            maint_set_r <= {SET_W{1'b0}};
            maint_addr_r <= 27'h000_0000;
        end else begin
            state_r <= state_nxt;
            // a sync barrier answers only once memory has drained
            done_r <= (take && claimed && !bad && !is_dsb) ||
                      ((state_r == ST_DSB) && !mem_outstanding_i);
            undef_r <= take && claimed && bad;
            if (region_word_en && !cp_write_i) begin
                rdata_r <= region_word;
            end
            maint_valid_r <= take && is_c7 && dec_valid && !bad;
            if (take && is_c7 && dec_valid && !bad) begin
                maint_setway_r <= dec_setway;
                maint_clean_r <= dec_clean;
                maint_inval_r <= dec_inval;
                maint_way_r <= dec_way;
                maint_set_r <= dec_set;
                maint_addr_r <= dec_addr;
            end
        end
    end

    // ----------------------------------------------------------------
    // region register
    // ----------------------------------------------------------------
    // straps are loaded while reset is held, so reset must last for
    // the synchroniser depth plus one edge
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            base_r <= strap_s[0] ? IMPL_BASE : `COB_BASE_ZERO;
            en_r <= strap_s[1];
        end else if (region_word_en && cp_write_i) begin
            base_r <= cp_wdata_i[`COB_BASE_MSB:`COB_BASE_LSB];
            en_r <= cp_wdata_i[`COB_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign cp_done_o = done_r;
    assign cp_undef_o = undef_r;
    assign cp_rdata_o = rdata_r;
    assign hold_instr_o = (state_r == ST_DSB);
    assign hold_mem_o = (state_r == ST_DMB);
    assign maint_valid_o = maint_valid_r;
    assign maint_setway_o = maint_setway_r;
    assign maint_clean_o = maint_clean_r;
    assign maint_inval_o = maint_inval_r;
    assign maint_way_o = maint_way_r;
    assign maint_set_o = maint_set_r;
    assign maint_addr_o = maint_addr_r;
    // stored base keeps every written bit; only the decode view masks
    assign ram_base_o = base_r & cob_base_mask(RAM_SIZE_CODE);
    assign ram_size_code_o = RAM_SIZE_CODE;
    assign ram_enable_o = en_r;

endmodule

`default_nettype wire

/* testbench/cob_cp_properties.sv */
// assertion checker for the coprocessor control block
`timescale 1ns/1ns
`default_nettype none
module cob_cp_props #(
    parameter CACHE_LOG2_KB = 2,
    parameter [4:0] RAM_SIZE_CODE = 5'h07
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // coprocessor port
    input wire logic cp_valid_i,
    input wire logic cp_write_i,
    input wire logic cp_priv_i,
    input wire logic [3:0] cp_crn_i,
    input wire logic [3:0] cp_crm_i,
    input wire logic [2:0] cp_op2_i,
    input wire logic [31:0] cp_wdata_i,
    input wire logic cp_ready_o,
    input wire logic cp_done_o,
    input wire logic cp_undef_o,
    input wire logic [31:0] cp_rdata_o,
    // memory, maintenance and region
    input wire logic mem_outstanding_i,
    input wire logic hold_instr_o,
    input wire logic hold_mem_o,
    input wire logic maint_valid_o,
    input wire logic maint_setway_o,
    input wire logic [1:0] maint_way_o,
    input wire logic [CACHE_LOG2_KB+2:0] maint_set_o,
    input wire logic [26:0] maint_addr_o,
    input wire logic [19:0] ram_base_o,
    input wire logic ram_enable_o
);
    // ------------------------------------------------
    // decoded requests
    // ------------------------------------------------
    // codes below 4KB or unlisted leave the base unmasked
    localparam int IGN = (RAM_SIZE_CODE >= 5'h03 && RAM_SIZE_CODE <= 5'h0e) ?
        RAM_SIZE_CODE - 3 : 0;
    wire logic tk = cp_valid_i && cp_ready_o;
    wire logic c7w = tk && cp_write_i && cp_crn_i == 4'h7;
    wire logic mnt = c7w && cp_priv_i && (cp_crm_i == 4'h6 ||
        cp_crm_i == 4'ha || cp_crm_i == 4'he);
    wire logic sw = mnt && cp_op2_i == 3'h2;
    wire logic ad = mnt && cp_op2_i == 3'h1;
    wire logic dsb = c7w && cp_crm_i == 4'ha && cp_op2_i == 3'h4;
    wire logic dmb = c7w && cp_crm_i == 4'ha && cp_op2_i == 3'h5;
    wire logic rg = tk && cp_crn_i == 4'h9 && cp_crm_i == 4'h1 &&
        cp_op2_i == 3'h0;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_way_field: assert property (sw |=>
        maint_valid_o && maint_setway_o &&
        maint_way_o == $past(cp_wdata_i[31:30])) else $error("way bad");
    a_set_field: assert property (sw |=>
        maint_set_o == $past(cp_wdata_i[CACHE_LOG2_KB+7:5]))
        else $error("set field bad");
    a_addr_field: assert property (ad |=>
        maint_valid_o && !maint_setway_o &&
        maint_addr_o == $past(cp_wdata_i[31:5])) else $error("addr bad");
    a_dsb_hold: assert property (dsb |=>
        hold_instr_o && !cp_ready_o && !cp_done_o)
        else $error("sync barrier not holding");
    a_dsb_release: assert property (hold_instr_o &&
        !mem_outstanding_i |=> !hold_instr_o && cp_done_o)
        else $error("sync barrier stuck");
    a_dmb_start: assert property (dmb |=>
        hold_mem_o && cp_done_o && !hold_instr_o)
        else $error("memory barrier bad");
    a_dmb_no_stall: assert property (hold_mem_o && !hold_instr_o &&
        cp_valid_i && cp_crn_i == 4'h9 |-> cp_ready_o)
        else $error("memory barrier stalled a register access");
    a_c7_read_undef: assert property (tk && !cp_write_i &&
        cp_crn_i == 4'h7 |=> cp_undef_o && !cp_done_o)
        else $error("cache register read not refused");
    a_region_user: assert property (rg && !cp_priv_i |=>
        cp_undef_o && $stable(ram_enable_o)) else $error("user access taken");
    a_region_read: assert property (rg && !cp_write_i &&
        cp_priv_i |=> cp_rdata_o[6:0] == {RAM_SIZE_CODE, 1'b0, ram_enable_o})
        else $error("region read word bad");
    a_enable_write: assert property (rg && cp_write_i &&
        cp_priv_i |=> ram_enable_o == $past(cp_wdata_i[0]))
        else $error("enable bad");
    a_base_mask: assert property
        ((ram_base_o & ((20'h0_0001 << IGN) - 20'h0_0001)) == 20'h0_0000)
        else $error("base low bits not ignored");

    c_dsb: cover property (dsb);
    c_dmb: cover property (dmb);
    c_setway: cover property (sw);
    c_dsb_drain: cover property (hold_instr_o && !mem_outstanding_i);
endmodule

bind cob_cp_ctrl cob_cp_props #(
    .CACHE_LOG2_KB(CACHE_LOG2_KB),
    .RAM_SIZE_CODE(RAM_SIZE_CODE)
) i_cob_cp_props (.clk_i, .rst_n_i, .cp_valid_i, .cp_write_i, .cp_priv_i,
    .cp_crn_i, .cp_crm_i, .cp_op2_i, .cp_wdata_i, .cp_ready_o, .cp_done_o,
    .cp_undef_o, .cp_rdata_o, .mem_outstanding_i, .hold_instr_o,
    .hold_mem_o, .maint_valid_o, .maint_setway_o, .maint_way_o,
    .maint_set_o, .maint_addr_o, .ram_base_o, .ram_enable_o);
`default_nettype wire

/* testbench/tb.sv */
// self-checking testbench for the coprocessor control block
`timescale 1ns/1ns
`default_nettype none
`include "cob_map.vh"
module tb;
    logic clk_i = 0;
    logic rst_n_i = 0;
    logic zs = 1;
    logic es = 1;
    logic v = 0;
    logic w = 0;
    logic p = 0;
    logic mo = 0;
    logic [3:0] crn = 4'h0;
    logic [3:0] crm = 4'h0;
    logic [2:0] op2 = 3'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rd;
    logic rdy, dn, ud, hi, hm, mv, msw, mcl, miv, en;
    logic [1:0] way;
    logic [4:0] set, sz;
    logic [26:0] adr;
    logic [19:0] base;
    int num_errors = 0;
    int checks_done = 0;

    cob_cp_ctrl i_cob_cp_ctrl (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .local_ram_at_zero_strap_i(zs), .local_ram_enable_strap_i(es),
        .cp_valid_i(v), .cp_write_i(w), .cp_priv_i(p), .cp_crn_i(crn),
        .cp_crm_i(crm), .cp_op2_i(op2), .cp_wdata_i(wd), .cp_ready_o(rdy),
        .cp_done_o(dn), .cp_undef_o(ud), .cp_rdata_o(rd),
        .mem_outstanding_i(mo), .hold_instr_o(hi), .hold_mem_o(hm),
        .maint_valid_o(mv), .maint_setway_o(msw), .maint_clean_o(mcl),
        .maint_inval_o(miv), .maint_way_o(way), .maint_set_o(set),
        .maint_addr_o(adr), .ram_base_o(base), .ram_size_code_o(sz),
        .ram_enable_o(en)
    );

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s,
            input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask

    task automatic do_reset(input logic z, input logic e);
        zs = z;
        es = e;
        rst_n_i = 0;
        cyc(10);
        rst_n_i = 1;
    endtask

    // one idle cycle first, so valid never toggles twice in a time step
    task automatic req(input logic wr, input logic pr, input logic [3:0] n,
            input logic [3:0] m, input logic [2:0] o, input logic [31:0] d);
        int t;
        t = 0;
        cyc(1);
        v = 1;
        w = wr;
        p = pr;
        crn = n;
        crm = m;
        op2 = o;
        wd = d;
        #1;
        while (rdy !== 1'b1 && t < 50) begin
            cyc(1);
            t++;
        end
        if (t == 50) chk("ready", 0, 1);
        cyc(1);
        v = 0;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset;
        chk("base", base, `COB_BASE_IMPL);
        chk("enable", en, 1);
        chk("size", sz, `COB_SIZE_RESET);
        req(0, 1, 9, 1, 0, 0);
        chk("done", dn, 1);
        chk("word", rd & 32'hffff_f07f,
            {`COB_BASE_IMPL, 12'h01d});
        do_reset(0, 0);
        chk("base", base, `COB_BASE_ZERO);
        chk("enable", en, 0);
        $display("test reset done");
    endtask

    task automatic t_region;
        req(1, 1, 9, 1, 0, 32'h1234_507d);
        chk("done", dn, 1);
        chk("enable", en, 1);
        chk("base", base, 20'h1_2340);
        req(0, 1, 9, 1, 0, 0);
        chk("word", rd & 32'hffff_f07f, 32'h1234_501d);
        chk("size", sz, `COB_SIZE_RESET);
        req(1, 0, 9, 1, 0, 0);
        chk("undef", ud, 1);
        chk("enable", en, 1);
        req(0, 0, 9, 1, 0, 0);
        chk("undef", ud, 1);
        chk("held", rd[31:12], 20'h1_2345);
        req(1, 1, 9, 1, 0, 0);
        chk("enable", en, 0);
        $display("test region done");
    endtask

    task automatic t_maint;
        logic [3:0] m;
        logic [2:0] o;
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            m = (i < 2) ? 4'h6 : (i < 4) ? 4'ha : 4'he;
            o = (i % 2) ? 3'h2 : 3'h1;
            d = (o == 3'h2) ? 32'h8000_02a0 : 32'hdead_bee0;
            req(1, 1, 7, m, o, d);
            chk("mvalid", mv, 1);
            chk("format", msw, o == 3'h2);
            chk("clean", mcl, m != 4'h6);
            chk("inval", miv, m != 4'ha);
            chk("way", way, d[31:30]);
            chk("set", set, d[9:5]);
            chk("addr", adr, d[31:5]);
        end
        $display("test maintenance done");
    endtask

    task automatic t_dsb;
        mo = 1;
        req(1, 0, 7, 4'ha, 3'h4, 0);
        chk("hold", hi, 1);
        chk("done", dn, 0);
        cyc(3);
        chk("hold", hi, 1);
        chk("ready", rdy, 0);
        mo = 0;
        cyc(1);
        chk("done", dn, 1);
        chk("hold", hi, 0);
        $display("test sync barrier done");
    endtask

    task automatic t_dmb;
        mo = 1;
        req(1, 0, 7, 4'ha, 3'h5, 0);
        chk("done", dn, 1);
        chk("holdmem", hm, 1);
        chk("hold", hi, 0);
        req(0, 1, 9, 1, 0, 0);
        chk("done", dn, 1);
        chk("holdmem", hm, 1);
        mo = 0;
        cyc(1);
        chk("holdmem", hm, 0);
        $display("test memory barrier done");
    endtask

    task automatic t_undef;
        req(0, 1, 7, 4'ha, 3'h4, 0);
        chk("undef", ud, 1);
        req(0, 0, 7, 4'ha, 3'h5, 0);
        chk("undef", ud, 1);
        req(1, 1, 7, 4'h3, 3'h0, 0);
        chk("undef", ud, 1);
        req(1, 0, 7, 4'h6, 3'h1, 0);
        chk("undef", ud, 1);
        chk("mvalid", mv, 0);
        req(1, 0, 7, 4'h5, 3'h4, 0);
        chk("done", dn, 1);
        req(1, 0, 7, 4'h0, 3'h4, 0);
        chk("undef", ud, 1);
        req(1, 1, 7, 4'h0, 3'h4, 0);
        chk("done", dn, 1);
        req(1, 1, 4'hb, 4'h0, 3'h0, 0);
        chk("undef", ud, 0);
        chk("done", dn, 0);
        $display("test refusals done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        num_errors++;
        conclude;
    end

    initial begin
        do_reset(1, 1);
        t_reset;
        t_region;
        t_maint;
        t_dsb;
        t_dmb;
        t_undef;
        conclude;
    end
endmodule
`default_nettype wire
